// File: hw/adpc_defines.svh
// constants for the audio dac pin control block
// Notes on behaviour
// - zero-detect goes high after 8192 frame periods of all-zero data on every channel
// - zero-detect drops at once when any channel data is nonzero
// - power-down input low holds power-down and resets all control state to defaults
// - parallel mode: soft-mute pin high starts mute ramp, low releases mute
// - parallel mode: format pin low is 32-bit msb-justified, high is 32-bit i2s
// - interface-select low gives 3-wire serial; high gives i2c or parallel
// - in 3-wire mode the mode pin serves as chip address bit 0
// - in i2c or 3-wire mode chip address bit 1 is compared for addressing
// - per-channel attenuation 0 to -127 db in 0.5 db steps plus mute
// - de-emphasis offered for 32, 44.1 and 48 khz sample rates
// - parallel mode: both tdm selector pins choose the tdm mode
// - 3-wire mode answers only while chip select is low; bits shift on serial clock
// - i2c mode shifts control bits in and out on the serial clock line
// - serial audio accepted as msb-justified, lsb-justified, i2s and tdm; decode never selects lsb, i2s and tdm only in parallel mode
// - tdm code 00 stereo, 01 tdm128, 10 tdm256, 11 tdm512
`ifndef ADPC_DEFINES_SVH
`define ADPC_DEFINES_SVH
`define ADPC_ZERO_FRAMES 14'h2000
`define ADPC_ZERO_CNT_W 14
`define ADPC_SLOT_W 32
`define ADPC_ATTEN_MUTE 8'hff
`define ADPC_ATTEN_DEFAULT 8'h00
`define ADPC_RAMP_STEP_FRAMES 4'h4
`define ADPC_OSR 9'h100
`endif

// File: hw/adpc_pkg.sv
// types for the audio dac pin control block
package adpc_pkg;
    typedef enum logic [1:0] {
        ADPC_CTL_THREEWIRE = 2'b00,
        ADPC_CTL_TWOWIRE = 2'b01,
        ADPC_CTL_PARALLEL = 2'b10
    } adpc_ctl_mode_type;
    typedef enum logic [1:0] {
        ADPC_TDM_STEREO = 2'b00,
        ADPC_TDM_128 = 2'b01,
        ADPC_TDM_256 = 2'b10,
        ADPC_TDM_512 = 2'b11
    } adpc_tdm_type;
    typedef enum logic [1:0] {
        ADPC_FMT_MSB = 2'b00,
        ADPC_FMT_LSB = 2'b01,
        ADPC_FMT_I2S = 2'b10
    } adpc_fmt_type;
    typedef enum logic [1:0] {
        ADPC_DEEMPH_OFF = 2'b00,
        ADPC_DEEMPH_32K = 2'b01,
        ADPC_DEEMPH_441K = 2'b10,
        ADPC_DEEMPH_48K = 2'b11
    } adpc_deemph_type;
    typedef struct packed {
        adpc_ctl_mode_type ctlMode;
        adpc_fmt_type fmt;
        adpc_tdm_type tdm;
        logic addrBit0;
        logic addrBit1;
        logic addrCheck;
    } adpc_cfg_type;
endpackage

// File: hw/adpc_pin_ctrl.sv
// pin-level control, mode decode, soft mute and zero detection
`timescale 1ns/100ps
`include "adpc_defines.svh"
module adpc_pin_ctrl
    import adpc_pkg::*;
(
    input wire logic core_clk, // master clock
    input wire logic rst, // synchronous reset, active high
    input wire logic power_down_n, // power-down pin, low active
    input wire logic iface_select_pin, // low: three-wire, high: i2c or parallel
    input wire logic control_mode_pin, // i2c/parallel select or address bit 0
    input wire logic chip_addr_bit1, // chip address bit 1
    input wire logic soft_mute_pin, // parallel-mode soft mute
    input wire logic format_select_pin, // parallel-mode audio format
    input wire logic tdm_select_bit0, // parallel-mode tdm selector 0
    input wire logic tdm_select_bit1, // parallel-mode tdm selector 1
    input wire logic ctrl_chip_select_n, // three-wire chip select, low active
    input wire logic ctrl_serial_clk, // three-wire or i2c serial clock
    input wire logic audio_bit_clk, // audio bit clock
    input wire logic audio_frame_clk, // audio frame clock
    input wire logic [3:0] audioDataIn, // audio_data_in_0..3
    input wire logic [7:0] atten [8], // per-channel attenuation, 0.5 db steps
    input wire adpc_deemph_type deemphSel, // de-emphasis rate select
    output logic zero_detect_out, // all channels zero
    output adpc_cfg_type cfg, // decoded configuration
    output logic powerDown, // power-down state
    output logic muteActive, // soft mute ramp running or held
    output logic [7:0] muteLevel, // current soft mute attenuation
    output logic [7:0] effAtten [8], // applied attenuation per channel
    output adpc_deemph_type deemphAct, // de-emphasis in use
    output logic ctrlSelected, // control access enabled
    output logic ctrlShiftPulse, // serial control bit strobe
    output logic [8:0] osrRatio // interpolation ratio
);
    // every pin is foreign to core_clk, so all pass two flip-flops
    localparam int NSYNC = 16;
    logic [NSYNC-1:0] pinRaw;
    logic [NSYNC-1:0] syncA_r;
    logic [NSYNC-1:0] syncB_r;
    assign pinRaw = {audioDataIn, audio_frame_clk, audio_bit_clk, ctrl_serial_clk,
        ctrl_chip_select_n, tdm_select_bit1, tdm_select_bit0, format_select_pin,
        soft_mute_pin, chip_addr_bit1, control_mode_pin, iface_select_pin, power_down_n};

    // two-stage synchronisers
    // cleared to zero so no false edge follows reset; power-down reads active
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= pinRaw;
            syncB_r <= syncA_r;
        end
    end


    // unpack the synchronised pins by role
    logic pdnS, ifSelS, modeS, cad1S, smuteS, difS, tdm0S, tdm1S, csnS, cclkS, bickS, lrckS;
    logic [3:0] dataS;
    assign {dataS, lrckS, bickS, cclkS, csnS, tdm1S, tdm0S, difS, smuteS, cad1S, modeS,
        ifSelS, pdnS} = syncB_r;

    // power-down forces all control state back to defaults
    logic ctlRst;
    assign ctlRst = rst | ~pdnS;
    assign powerDown = ~pdnS;

    // mode decode
    // straps only give format and tdm once both select pins are high
    adpc_cfg_type cfg_nxt;
    always_comb begin
        cfg_nxt = '0;
        if (!ifSelS) begin
            cfg_nxt.ctlMode = ADPC_CTL_THREEWIRE;
            cfg_nxt.addrBit0 = modeS;
        end else if (!modeS) begin
            cfg_nxt.ctlMode = ADPC_CTL_TWOWIRE;
        end else begin
            cfg_nxt.ctlMode = ADPC_CTL_PARALLEL;
        end
        cfg_nxt.addrCheck = (cfg_nxt.ctlMode != ADPC_CTL_PARALLEL);
        cfg_nxt.addrBit1 = cfg_nxt.addrCheck & cad1S;
        if (cfg_nxt.ctlMode == ADPC_CTL_PARALLEL) begin
            cfg_nxt.fmt = difS ? ADPC_FMT_I2S : ADPC_FMT_MSB;
            cfg_nxt.tdm = adpc_tdm_type'({tdm1S, tdm0S});
        end else begin
            cfg_nxt.fmt = ADPC_FMT_MSB;
            cfg_nxt.tdm = ADPC_TDM_STEREO;
        end
    end

    // configuration register
    // registered so decode glitches on strap changes never reach the outputs
    always_ff @(posedge core_clk) begin
        if (ctlRst) begin
            cfg <= '0;
        end else begin
            cfg <= cfg_nxt;
        end
    end

    // edge detection on the synchronised clocks
    logic bickD_r, lrckD_r, cclkD_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bickD_r <= 1'b0;
            lrckD_r <= 1'b0;
            cclkD_r <= 1'b0;
        end else begin
            bickD_r <= bickS;
            lrckD_r <= lrckS;
            cclkD_r <= cclkS;
        end
    end

    // one-cycle strobes; a link clock above half core rate would be missed
    logic bickRise, lrckRise, lrckEdge, cclkRise;
    assign bickRise = bickS & ~bickD_r;
    assign lrckRise = lrckS & ~lrckD_r;
    assign lrckEdge = lrckS ^ lrckD_r;
    assign cclkRise = cclkS & ~cclkD_r;

    // control port enable and bit strobe
    always_comb begin
        case (cfg.ctlMode)
            ADPC_CTL_THREEWIRE: ctrlSelected = ~csnS;
            ADPC_CTL_TWOWIRE: ctrlSelected = 1'b1;
            default: ctrlSelected = 1'b0;
        endcase
    end
    assign ctrlShiftPulse = ctrlSelected & cclkRise & ~powerDown;

    // per-slot nonzero tracking: any one bit in a half-frame marks it live
    logic slotNonzero_r;
    logic anyBit;
    assign anyBit = |dataS;
    always_ff @(posedge core_clk) begin
        if (ctlRst) begin
            slotNonzero_r <= 1'b0;
        end else if (lrckEdge) begin
            slotNonzero_r <= bickRise & anyBit;
        end else if (bickRise && anyBit) begin
            slotNonzero_r <= 1'b1;
        end
    end
    // live now, or earlier in this half-frame
    logic liveNow;
    assign liveNow = slotNonzero_r | (bickRise & anyBit);

    // zero frame counter, saturates at the threshold
    // saturating rather than wrapping keeps the flag up through long silence
    logic [`ADPC_ZERO_CNT_W-1:0] zeroCnt_r;
    always_ff @(posedge core_clk) begin
        if (ctlRst || liveNow) begin
            zeroCnt_r <= '0;
        end else if (lrckRise && zeroCnt_r != `ADPC_ZERO_FRAMES) begin
            zeroCnt_r <= zeroCnt_r + 1'b1;
        end
    end

    // zero flag; the live term clears it on the edge after a live bit is seen, one cycle before the counter would
    always_ff @(posedge core_clk) begin
        if (ctlRst) begin
            zero_detect_out <= 1'b0;
        end else begin
            zero_detect_out <= (zeroCnt_r == `ADPC_ZERO_FRAMES) & ~liveNow;
        end
    end

    // soft mute ramp: one half-db step every few frames, up to full mute
    // free-running divider: the first step may come up to three frames early
    logic [3:0] rampDiv_r;
    logic rampTick;
    assign rampTick = lrckRise && rampDiv_r == `ADPC_RAMP_STEP_FRAMES - 4'h1;
    always_ff @(posedge core_clk) begin
        if (ctlRst) begin
            rampDiv_r <= '0;
        end else if (lrckRise) begin
            rampDiv_r <= rampTick ? 4'h0 : rampDiv_r + 4'h1;
        end
    end

    // the mute pin only counts in parallel mode
    logic smuteReq;
    assign smuteReq = (cfg.ctlMode == ADPC_CTL_PARALLEL) & smuteS;
    always_ff @(posedge core_clk) begin
        if (ctlRst) begin
            muteLevel <= '0;
        end else if (!smuteReq) begin
            muteLevel <= '0;
        end else if (rampTick && muteLevel != `ADPC_ATTEN_MUTE) begin
            muteLevel <= muteLevel + 8'h01;
        end
    end
    // active while requested or while any mute attenuation remains
    assign muteActive = smuteReq | (muteLevel != 8'h00);

    // per-channel attenuation, the larger of volume and mute wins
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++) begin : g_chan
            always_ff @(posedge core_clk) begin
                if (ctlRst) begin
                    effAtten[ch] <= `ADPC_ATTEN_DEFAULT;
                end else begin
                    effAtten[ch] <= (atten[ch] > muteLevel) ? atten[ch] : muteLevel;
                end
            end
        end
    endgenerate


    // de-emphasis selection and fixed oversampling ratio
    // the ratio is fixed; kept in a register so reset shows it too
    always_ff @(posedge core_clk) begin
        if (ctlRst) begin
            deemphAct <= ADPC_DEEMPH_OFF;
            osrRatio <= `ADPC_OSR;
        end else begin
            deemphAct <= deemphSel;
            osrRatio <= `ADPC_OSR;
        end
    end
endmodule

// File: tb/adpc_pin_ctrl_chk.sv
// checker for the pin control block
`timescale 1ns/100ps
module adpc_pin_ctrl_chk
    import adpc_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input wire logic power_down_n, // pd pin
    input wire logic iface_select_pin, // if sel
    input wire logic control_mode_pin, // mode pin
    input wire logic chip_addr_bit1, // addr 1
    input wire logic soft_mute_pin, // mute pin
    input wire logic [3:0] audioDataIn, // data
    input wire logic ctrl_serial_clk, // serial clock pin
    input wire logic ctrlShiftPulse, // bit strobe
    input wire logic zero_detect_out, // zero flag
    input wire adpc_cfg_type cfg, // config
    input wire logic powerDown, // pd state
    input wire logic muteActive, // muting
    input wire logic [7:0] muteLevel, // level
    input wire logic [8:0] osrRatio // ratio
);
    logic [16:0] quietCnt_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // zero-data run, saturating so it never wraps back to small
    always_ff @(posedge core_clk) begin
        if (rst || audioDataIn != 4'h0) begin
            quietCnt_r <= 17'h00000;
        end else if (!quietCnt_r[16]) begin
            quietCnt_r <= quietCnt_r + 17'h00001;
        end
    end
    a_osr_fixed: assert property (osrRatio == 9'h100) else $error("ratio wrong");
    a_pd_enter: assert property ((!power_down_n)[*3] |-> powerDown) else $error("no pd");
    a_pd_clear:
        assert property (powerDown[*2] |-> cfg == '0 && muteLevel == 8'h00)
        else $error("state kept in power-down");
    a_mode_three:
        assert property ((power_down_n && !iface_select_pin
            && $stable({control_mode_pin, chip_addr_bit1}))[*7]
            |-> cfg.ctlMode == ADPC_CTL_THREEWIRE && cfg.addrBit0 == control_mode_pin
            && cfg.addrBit1 == chip_addr_bit1 && cfg.addrCheck) else $error("bad 3-wire");
    a_mode_two:
        assert property ((power_down_n && iface_select_pin && !control_mode_pin
            && $stable(chip_addr_bit1))[*7] |-> cfg.ctlMode == ADPC_CTL_TWOWIRE
            && cfg.addrBit1 == chip_addr_bit1 && cfg.addrCheck) else $error("bad i2c");
    a_mode_par:
        assert property ((power_down_n && iface_select_pin && control_mode_pin)[*7]
            |-> cfg.ctlMode == ADPC_CTL_PARALLEL && !cfg.addrCheck) else $error("bad par");
    a_zero_drop:
        assert property (zero_detect_out && audioDataIn != 4'h0 |-> ##[1:12] !zero_detect_out)
        else $error("zero flag stuck");
    a_zero_quiet:
        assert property ($rose(zero_detect_out) |-> quietCnt_r > 17'd65000)
        else $error("zero flag early");
    a_mute_off:
        assert property ((!soft_mute_pin)[*6] |-> muteLevel == 8'h00 && !muteActive)
        else $error("mute not released");
    a_shift_edge:
        assert property (ctrlShiftPulse |-> $past(ctrl_serial_clk, 2)
            && !$past(ctrl_serial_clk, 3)) else $error("strobe without clock rise");
    c_zero: cover property ($rose(zero_detect_out));
    c_mute: cover property ($rose(muteActive));
    c_pd: cover property ($rose(powerDown));
endmodule
bind adpc_pin_ctrl adpc_pin_ctrl_chk chk (.*);

// File: tb/adpc_audio_src.sv
// audio source model: bit clock, frame clock and data lines
`timescale 1ns/100ps
module adpc_audio_src (
    input wire logic [3:0] fill, // data to send
    output logic bitClk, // 80 ns bit clock
    output logic frameClk, // 160 ns frame clock
    output logic [3:0] dataOut // data lines
);
    // free-running clocks; rate compressed to keep the run short
    initial begin
        bitClk = 1'b0;
        frameClk = 1'b0;
        dataOut = 4'h0;
        forever begin
            #40 bitClk = ~bitClk;
            // launch on the fall so the rise samples settled data
            if (!bitClk) begin
                frameClk = ~frameClk;
                dataOut = fill;
            end
        end
    end
endmodule

// File: tb/tb.sv
// self-checking bench for the pin control block
`timescale 1ns/100ps
module tb;
    import adpc_pkg::*;
    logic core_clk, rst, power_down_n, iface_select_pin, control_mode_pin, chip_addr_bit1;
    logic soft_mute_pin, format_select_pin, tdm_select_bit0, tdm_select_bit1;
    logic ctrl_chip_select_n, ctrl_serial_clk, audio_bit_clk, audio_frame_clk;
    logic zero_detect_out, powerDown, muteActive, ctrlSelected, ctrlShiftPulse;
    logic [3:0] audioDataIn, fill;
    logic [7:0] atten [8];
    logic [7:0] effAtten [8];
    logic [7:0] muteLevel;
    logic [8:0] osrRatio;
    adpc_deemph_type deemphSel, deemphAct;
    adpc_cfg_type cfg;
    int err_total, n_checks, seed;
    adpc_pin_ctrl dut (.*);
    adpc_audio_src src (.fill(fill), .bitClk(audio_bit_clk), .frameClk(audio_frame_clk),
        .dataOut(audioDataIn));
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        err_total++;
        $display("timeout");
        test_done();
    end
    function automatic adpc_ctl_mode_type expMode(logic sel, logic mode);
        return !sel ? ADPC_CTL_THREEWIRE : (mode ? ADPC_CTL_PARALLEL : ADPC_CTL_TWOWIRE);
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic waitN(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // main sequence, inputs change on the falling edge
    initial begin
        seed = 32'h9d2f50c5;
        err_total = 0;
        n_checks = 0;
        {rst, power_down_n, iface_select_pin, control_mode_pin} = 4'hf;
        {chip_addr_bit1, soft_mute_pin, format_select_pin, tdm_select_bit0} = 4'h0;
        {tdm_select_bit1, ctrl_chip_select_n, ctrl_serial_clk} = 3'h2;
        deemphSel = ADPC_DEEMPH_OFF;
        fill = 4'h0;
        foreach (atten[i]) atten[i] = 8'h00;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        // random straps, first four passes force each mode
        for (int k = 0; k < 24; k++) begin
            {iface_select_pin, control_mode_pin, chip_addr_bit1, format_select_pin,
                tdm_select_bit1, tdm_select_bit0, ctrl_chip_select_n}
                = 7'($random(seed));
            ctrl_serial_clk = k[4];
            if (k < 4) {iface_select_pin, control_mode_pin} = k[1:0];
            deemphSel = adpc_deemph_type'(k[1:0]);
            foreach (atten[i]) atten[i] = 8'($random(seed));
            waitN(8);
            chk("mode", cfg.ctlMode, expMode(iface_select_pin, control_mode_pin));
            if (!iface_select_pin) chk("addr0", cfg.addrBit0, control_mode_pin);
            if (!iface_select_pin) chk("select", ctrlSelected, !ctrl_chip_select_n);
            if (!(iface_select_pin && control_mode_pin)) begin
                chk("addr1", {cfg.addrCheck, cfg.addrBit1}, {1'b1, chip_addr_bit1});
            end else begin
                chk("fmt", cfg.fmt, format_select_pin ? ADPC_FMT_I2S : ADPC_FMT_MSB);
                chk("tdm", cfg.tdm, {tdm_select_bit1, tdm_select_bit0});
            end
            chk("deemph", deemphAct, deemphSel);
            foreach (effAtten[i]) chk("atten", effAtten[i], atten[i]);
            chk("osr", osrRatio, 9'h100);
        end
        $display("mode test done");
        // mute ramp in parallel mode, then power-down mid-ramp
        {iface_select_pin, control_mode_pin, soft_mute_pin} = 3'h7;
        waitN(300);
        chk("ramp", muteLevel inside {[8'd8:8'd10]}, 1'b1);
        power_down_n = 1'b0;
        waitN(6);
        chk("pd", {powerDown, cfg, muteLevel}, {1'b1, 9'h000, 8'h00});
        power_down_n = 1'b1;
        soft_mute_pin = 1'b0;
        waitN(8);
        chk("unmute", {muteActive, muteLevel}, 9'h000);
        iface_select_pin = 1'b0;
        soft_mute_pin = 1'b1;
        waitN(100);
        chk("mute ignored", {muteActive, muteLevel}, 9'h000);
        soft_mute_pin = 1'b0;
        $display("mute test done");
        // zero run: not early, then set, then dropped by nonzero data
        fill = 4'h5;
        waitN(20);
        fill = 4'h0;
        waitN(8192 * 8 - 160);
        chk("zero early", zero_detect_out, 1'b0);
        waitN(320);
        chk("zero set", zero_detect_out, 1'b1);
        fill = 4'($random(seed)) | 4'h1;
        waitN(12);
        chk("zero drop", zero_detect_out, 1'b0);
        $display("zero test done");
        test_done();
    end
endmodule
